//--- rtl/asgate_top.sv
// Acquisition start trigger gate with its Wishbone register file.
// Assumes frame start triggers and line levels are synchronous to clk_i
// only for the frame trigger; external lines are synchronised here.
`timescale 1ns/100ps
`default_nettype none
module asgate_top
(
	input  wire logic        clk_i,                  // System clock, 100 MHz.
	input  wire logic        rst_i,                  // Synchronous reset.
	input  wire logic [7:0]  wb_adr_i,               // Wishbone byte address.
	input  wire logic [31:0] wb_dat_i,               // Wishbone write data.
	input  wire logic [3:0]  wb_sel_i,               // Byte enables.
	input  wire logic        wb_we_i,                // Write enable.
	input  wire logic        wb_cyc_i,               // Cycle.
	input  wire logic        wb_stb_i,               // Strobe.
	output logic [31:0]      wb_dat_o,               // Read data.
	output logic             wb_ack_o,               // Acknowledge.
	input  wire logic        input_line_one_i,       // External line one.
	input  wire logic        gpio_line_three_i,      // GPIO line three level.
	input  wire logic        frame_trigger_i,        // Frame start request pulse.
	output logic             frame_trigger_o,        // Accepted frame start.
	output logic             start_trigger_o,        // Acquisition start taken.
	output logic             wait_start_o            // Gate waiting for start.
);

	// ****************************************************************
	// Configuration state.
	// ****************************************************************
	logic        gate_enable_setting;   // Gating on.
	logic [1:0]  start_source_select;   // Start trigger source.
	logic        edge_polarity_select;  // 1 = falling.
	logic        trigger_target_select; // 1 = acquisition start target.
	logic        capture_run_mode;      // 1 = continuous.
	logic        gpio_line_three_is_input;        // GPIO line three set as input.
	logic [7:0]  frames_per_burst;      // Frames per burst, 1..255.
	logic        capture_running;       // Between begin and end commands.
	logic        soft_trigger_cmd;      // One-cycle soft trigger strobe.
	logic [7:0]  frame_count;           // Accepted frames this burst.
	logic        line_level;            // Selected external line level.
	logic        line_pulse;            // Edge pulse from detector.
	logic        hw_start;              // Qualified hardware start.
	logic        any_start;             // Start from the selected source.
	logic        accept_frame;          // Frame trigger passes the gate.
	logic        bus_write;             // Write taken this cycle.

	// Gate states.
	typedef enum logic [0:0]
	{
		WAIT_START,
		WAIT_FRAME
	} asg_state_type;
	asg_state_type state;

	// ****************************************************************
	// Wishbone slave.
	// ****************************************************************
	// The slave answers one cycle after the strobe; ack drops next cycle
	// so a held strobe is not taken twice. A write lands at the edge where
	// the master sees ack high, so a request dropped early changes nothing.
	assign bus_write = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o & wb_sel_i[0];

	// Acknowledge every access, mapped or not, to keep the bus moving.
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			wb_ack_o <= 1'b0;
		else
			wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
	end

	// Control register writes.
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			{gpio_line_three_is_input, capture_run_mode, trigger_target_select,
			 edge_polarity_select, start_source_select, gate_enable_setting} <= asgate_pkg::CTRL_RESET;
		end
		else if (bus_write && wb_adr_i == asgate_pkg::ASG_CTRL_OFFSET)
		begin
			gate_enable_setting   <= wb_dat_i[asgate_pkg::CTRL_GATE_ENABLE_BIT];
			start_source_select   <= wb_dat_i[asgate_pkg::CTRL_SOURCE_LSB +: 2];
			edge_polarity_select  <= wb_dat_i[asgate_pkg::CTRL_EDGE_BIT];
			trigger_target_select <= wb_dat_i[asgate_pkg::CTRL_TARGET_BIT];
			capture_run_mode      <= wb_dat_i[asgate_pkg::CTRL_RUN_MODE_BIT];
			gpio_line_three_is_input        <= wb_dat_i[asgate_pkg::CTRL_GPIO_LINE_THREE_INPUT_BIT];
		end
	end

	// burst range clamp
	// Zero is out of range and is ignored, so the count never becomes 0.
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			frames_per_burst <= asgate_pkg::FRAMES_RESET;
		else if (bus_write && wb_adr_i == asgate_pkg::ASG_COUNT_OFFSET
			&& wb_dat_i[7:0] >= asgate_pkg::FRAMES_MIN)
			frames_per_burst <= wb_dat_i[7:0];
	end

	// one soft pulse
	// The strobe lasts a single cycle per executed write, and only counts
	// while the target selection names acquisition start.
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			soft_trigger_cmd <= 1'b0;
		else
			soft_trigger_cmd <= bus_write && wb_adr_i == asgate_pkg::ASG_CMD_OFFSET
				&& wb_dat_i[asgate_pkg::CMD_SOFT_TRIGGER_BIT] && trigger_target_select;
	end

	// begin and end
	// Capture running flag follows begin and end commands; end wins a tie.
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			capture_running <= 1'b0;
		else if (bus_write && wb_adr_i == asgate_pkg::ASG_CMD_OFFSET)
		begin
			if (wb_dat_i[asgate_pkg::CMD_END_BIT])
				capture_running <= 1'b0;
			else if (wb_dat_i[asgate_pkg::CMD_BEGIN_BIT])
				capture_running <= 1'b1;
		end
	end

	// Read mux; unmapped addresses read as zero.
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			wb_dat_o <= 32'h0000_0000;
		else if (wb_adr_i == asgate_pkg::ASG_CTRL_OFFSET)
			wb_dat_o <= {25'h0, gpio_line_three_is_input, capture_run_mode, trigger_target_select,
				edge_polarity_select, start_source_select, gate_enable_setting};
		else if (wb_adr_i == asgate_pkg::ASG_COUNT_OFFSET)
			wb_dat_o <= {24'h0, frames_per_burst};
		else if (wb_adr_i == asgate_pkg::ASG_STATUS_OFFSET)
			wb_dat_o <= {16'h0, frame_count, 5'h0, capture_running,
				state == WAIT_FRAME, state == WAIT_START};
		else
			wb_dat_o <= 32'h0000_0000;
	end

	// ****************************************************************
	// Start trigger sources.
	// ****************************************************************
	// line source select
	// Line three only counts when configured as an input.
	always_comb
	begin
		if (start_source_select == asgate_pkg::ASG_SRC_LINE_THREE)
			line_level = gpio_line_three_i & gpio_line_three_is_input;
		else
			line_level = input_line_one_i;
	end

	asgate_edge u_edge
	(
		.clk_i     (clk_i),
		.rst_i     (rst_i),
		.level_i   (line_level),
		.falling_i (edge_polarity_select),
		.pulse_o   (line_pulse)
	);

	assign hw_start = line_pulse && (start_source_select == asgate_pkg::ASG_SRC_LINE_ONE
		|| (start_source_select == asgate_pkg::ASG_SRC_LINE_THREE && gpio_line_three_is_input));
	assign any_start = (start_source_select == asgate_pkg::ASG_SRC_SOFTWARE) ? soft_trigger_cmd : hw_start;

	// ****************************************************************
	// Gate.
	// ****************************************************************
	// gate off passes
	assign accept_frame = frame_trigger_i & (~gate_enable_setting | state == WAIT_FRAME);

	always_ff @(posedge clk_i)
	begin
		if (rst_i || !gate_enable_setting)
		begin
			state       <= WAIT_START;
			frame_count <= 8'h00;
		end
		else
		begin
			case (state)
				WAIT_START:
				begin
					frame_count <= 8'h00;
					if (any_start)
						state <= WAIT_FRAME;
				end
				WAIT_FRAME:
				begin
					if (accept_frame)
					begin
						if (frame_count + 8'h01 >= frames_per_burst)
						begin
							frame_count <= 8'h00;
							state       <= WAIT_START;
						end
						else
							frame_count <= frame_count + 8'h01;
					end
				end
				default:
					state <= WAIT_START;
			endcase
		end
	end

	// Registered frame and start outputs; the wait flag is combinational.
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			frame_trigger_o <= 1'b0;
			start_trigger_o <= 1'b0;
		end
		else
		begin
			frame_trigger_o <= accept_frame;
			start_trigger_o <= gate_enable_setting && state == WAIT_START && any_start;
		end
	end

	assign wait_start_o = gate_enable_setting && state == WAIT_START;

endmodule : asgate_top
`default_nettype wire

//--- rtl/asgate_pkg.sv
// Package for the acquisition start trigger gate: register map, field layout,
// reset values and the source enumeration used by the gate.
// Assumes a 32-bit classic Wishbone bus with word-aligned registers.
package asgate_pkg;

	// ****************************************************************
	// Register offsets (byte addresses).
	// ****************************************************************
	localparam logic [7:0] ASG_CTRL_OFFSET    = 8'h00; // Gate and source setup.
	localparam logic [7:0] ASG_COUNT_OFFSET   = 8'h04; // Frames per burst.
	localparam logic [7:0] ASG_CMD_OFFSET     = 8'h08; // Command strobes.
	localparam logic [7:0] ASG_STATUS_OFFSET  = 8'h0C; // Gate state and count.

	// ****************************************************************
	// Field positions.
	// ****************************************************************
	localparam int CTRL_GATE_ENABLE_BIT  = 0;  // Gating switched on.
	localparam int CTRL_SOURCE_LSB       = 1;  // Two-bit source select.
	localparam int CTRL_EDGE_BIT         = 3;  // 1 = falling edge.
	localparam int CTRL_TARGET_BIT       = 4;  // 1 = acquisition start.
	localparam int CTRL_RUN_MODE_BIT     = 5;  // 1 = continuous.
	localparam int CTRL_GPIO_LINE_THREE_INPUT_BIT  = 6;  // Line three set as input.
	localparam int CMD_SOFT_TRIGGER_BIT  = 0;  // Soft trigger strobe.
	localparam int CMD_BEGIN_BIT         = 1;  // Capture begin strobe.
	localparam int CMD_END_BIT           = 2;  // Capture end strobe.
	localparam int STATUS_WAIT_START_BIT = 0;  // Waiting for acquisition start.
	localparam int STATUS_WAIT_FRAME_BIT = 1;  // Waiting for frame start.
	localparam int STATUS_RUNNING_BIT    = 2;  // Capture running.
	localparam int STATUS_COUNT_LSB      = 8;  // Accepted frame count.

	// ****************************************************************
	// Reset values and limits.
	// ****************************************************************
	localparam logic [6:0] CTRL_RESET          = 7'h00;
	localparam logic [7:0] FRAMES_RESET        = 8'h01;
	localparam logic [7:0] FRAMES_MIN          = 8'h01;
	localparam logic [7:0] FRAMES_MAX          = 8'hFF;

	// Source selection encodings.
	typedef enum logic [1:0]
	{
		ASG_SRC_SOFTWARE = 2'h0,
		ASG_SRC_LINE_ONE = 2'h1,
		ASG_SRC_LINE_THREE = 2'h2
	} asg_source_type;

endpackage : asgate_pkg

//--- rtl/asgate_edge.sv
// Edge detector for the external start input.
// Synchronises the line level into the clk_i domain before the edge compare.
`timescale 1ns/100ps
`default_nettype none
module asgate_edge
(
	input  wire logic clk_i,             // System clock.
	input  wire logic rst_i,             // Synchronous reset.
	input  wire logic level_i,           // Selected line level.
	input  wire logic falling_i,         // 1 selects falling edges.
	output logic      pulse_o            // One cycle per chosen edge.
);

	logic sync_first;   // First synchroniser stage, read only by sync_second.
	logic sync_second;  // Second synchroniser stage.
	logic level_prev;   // Previous stable level for edge compare.

	// ****************************************************************
	// Synchroniser and edge compare.
	// ****************************************************************
	// sync and pulse
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			sync_first  <= 1'b0;
			sync_second <= 1'b0;
			level_prev  <= 1'b0;
		end
		else
		begin
			sync_first  <= level_i;
			sync_second <= sync_first;
			level_prev  <= sync_second;
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			pulse_o <= 1'b0;
		else if (falling_i)
			pulse_o <= level_prev & ~sync_second;
		else
			pulse_o <= ~level_prev & sync_second;
	end

endmodule : asgate_edge
`default_nettype wire

//--- verif/asgate_chk.sv
// Port checker for the start trigger gate.
// Assumes one clock domain and the bind at the foot.
`timescale 1ns/100ps
`default_nettype none
module asgate_chk
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_ack_o,
	input wire logic frame_trigger_i,
	input wire logic frame_trigger_o,
	input wire logic start_trigger_o,
	input wire logic wait_start_o
);
	// ********************************
	// Clocking and step sequences.
	// ********************************
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	sequence s_req;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	sequence s_blocked;
		wait_start_o && frame_trigger_i;
	endsequence
	a_ack_answer: assert property (s_req |=> wb_ack_o) else $error("ack late");
	a_ack_single: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
	a_ack_cause: assert property ($rose(wb_ack_o) |-> $past(wb_stb_i)) else $error("ack unasked");
	a_frame_blocked: assert property (s_blocked |=> !frame_trigger_o) else $error("frame passed");
	a_frame_cause: assert property (frame_trigger_o |-> $past(frame_trigger_i)) else $error("frame unasked");
	a_start_opens: assert property (start_trigger_o |-> !wait_start_o) else $error("gate shut");
	a_start_single: assert property (start_trigger_o |=> !start_trigger_o) else $error("pulse long");
	// closing follows a frame or a write.
	a_wait_close: assert property ($rose(wait_start_o) |->
		frame_trigger_o || wb_ack_o || $past(wb_ack_o)) else $error("gate closed early");
	// leaving needs a start or a write.
	a_wait_leave: assert property ($fell(wait_start_o) |->
		start_trigger_o || wb_ack_o || $past(wb_ack_o)) else $error("gate opened alone");
endmodule : asgate_chk
bind asgate_top asgate_chk asgate_chk_inst (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o,
	.frame_trigger_i, .frame_trigger_o, .start_trigger_o, .wait_start_o);
`default_nettype wire

//--- verif/asgate_src.sv
// External trigger source model for one input line.
// Assumes one request pulse from the bench per wanted edge.
`timescale 1ns/100ps
`default_nettype none
module asgate_src
(
	input  wire logic clk_i,  // Bench clock.
	input  wire logic fire_i, // Request one line change.
	output var  logic line_o  // Line level, low at start.
);
	initial line_o = 1'h0;
	// each request flips the line, so wrong edges come too.
	always @(posedge clk_i)
	begin
		line_o <= line_o ^ fire_i;
	end
endmodule : asgate_src
`default_nettype wire

//--- verif/tb.sv
// Bench for the start trigger gate: bus tasks, scenarios, verdict.
// Assumes the design, its checker bind and the line source model.
`timescale 1ns/100ps
`default_nettype none
module tb;
	// ********************************
	// Signals and instances.
	// ********************************
	logic        clk_i = 1'h0;
	logic        rst_i = 1'h1;
	logic [7:0]  wb_adr_i = 8'h00;
	logic [31:0] wb_dat_i = 32'h0;
	logic [3:0]  wb_sel_i = 4'hF;  // Whole words only.
	logic        wb_we_i = 1'h0;
	logic        wb_cyc_i = 1'h0;
	logic        wb_stb_i = 1'h0;
	logic        frame_trigger_i = 1'h0;
	logic [1:0]  fire = 2'h0;      // Edge requests per line.
	logic [31:0] wb_dat_o;
	logic        wb_ack_o, frame_trigger_o, start_trigger_o, wait_start_o;
	logic        input_line_one_i, gpio_line_three_i;
	int          n_mismatch = 0;
	int          check_count = 0;
	always #5 clk_i = ~clk_i;
	asgate_top asgate_top_inst (.clk_i, .rst_i, .wb_adr_i, .wb_dat_i, .wb_sel_i, .wb_we_i, .wb_cyc_i,
		.wb_stb_i, .wb_dat_o, .wb_ack_o, .input_line_one_i, .gpio_line_three_i, .frame_trigger_i,
		.frame_trigger_o, .start_trigger_o, .wait_start_o);
	asgate_src asgate_src_one_inst (.clk_i, .fire_i(fire[0]), .line_o(input_line_one_i));
	asgate_src asgate_src_three_inst (.clk_i, .fire_i(fire[1]), .line_o(gpio_line_three_i));
	// ********************************
	// Bus, compare and stimulus tasks.
	// ********************************
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		wb_we_i <= w;
		wb_adr_i <= a;
		wb_dat_i <= d;
		wb_cyc_i <= 1'h1;
		wb_stb_i <= 1'h1;
		// Only the watchdog ends a wait that never sees ack.
		do
		begin
			@(posedge clk_i);
		end
		while (wb_ack_o !== 1'h1);
		q = wb_dat_o;
		wb_cyc_i <= 1'h0;
		wb_stb_i <= 1'h0;
		@(posedge clk_i);
	endtask : xfer
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("BAD %s exp %h got %h", nm, e, g);
		end
	endtask : chk
	task automatic chkb(input string nm, input logic e, input logic g);
		check_count++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("BAD %s exp %b got %b", nm, e, g);
		end
	endtask : chkb
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		xfer(1'h1, a, d, q);
	endtask : wr
	task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] e);
		logic [31:0] q;
		xfer(1'h0, a, 32'h0, q);
		chk(nm, e, q);
	endtask : rd
	// A one-cycle frame request; the answer shows one cycle later.
	task automatic frame(input logic e);
		frame_trigger_i <= 1'h1;
		@(posedge clk_i);
		frame_trigger_i <= 1'h0;
		@(posedge clk_i);
		chkb("frame_trigger_o", e, frame_trigger_o);
	endtask : frame
	task automatic watch(input int n, output logic s);
		s = 1'h0;
		repeat (n)
		begin
			@(posedge clk_i);
			s = s | (start_trigger_o === 1'h1);
		end
	endtask : watch
	// ********************************
	// Scenarios.
	// ********************************
	task automatic t_soft;
		logic s;
		rd("frames reset", 8'h04, {24'h0, asgate_pkg::FRAMES_RESET});
		rd("unmapped", 8'h10, 32'h0);
		wr(8'h00, 32'h20);
		frame(1'h1);
		frame(1'h1);
		wr(8'h04, 32'h2);
		wr(8'h00, 32'h31);
		rd("ctrl", 8'h00, 32'h31);
		wr(8'h08, 32'h2);
		chkb("wait_start_o", 1'h1, wait_start_o);
		frame(1'h0);
		wr(8'h08, 32'h1);
		watch(6, s);
		chkb("start_trigger_o", 1'h1, s);
		frame(1'h1);
		rd("status burst", 8'h0C, 32'h106);
		frame(1'h1);
		chkb("wait_start_o", 1'h1, wait_start_o);
		frame(1'h0);
		wr(8'h04, 32'h0);
		rd("frames kept", 8'h04, 32'h2);
		wr(8'h04, 32'hFF);
		rd("frames max", 8'h04, 32'hFF);
		wr(8'h08, 32'h4);
		rd("status end", 8'h0C, 32'h1);
		wr(8'h00, 32'h21);
		wr(8'h08, 32'h1);
		watch(6, s);
		chkb("start_trigger_o", 1'h0, s);
		chkb("wait_start_o", 1'h1, wait_start_o);
		$display("test soft done");
	endtask : t_soft
	// Both lines, both polarities; each pair of flips gives one right edge.
	task automatic t_lines;
		logic s;
		logic nl;
		wr(8'h04, 32'h1);
		for (int k = 0; k < 2; k++)
		begin
			for (int f = 0; f < 2; f++)
			begin
				wr(8'h00, (k ? 32'h75 : 32'h33) | 32'(f * 8));
				repeat (2)
				begin
					nl = k ? ~gpio_line_three_i : ~input_line_one_i;
					fire[k] <= 1'h1;
					@(posedge clk_i);
					fire[k] <= 1'h0;
					watch(10, s);
					chkb("start_trigger_o", nl ^ f[0], s);
					if (nl ^ f[0])
					begin
						frame(1'h1);
						chkb("wait_start_o", 1'h1, wait_start_o);
					end
				end
			end
		end
		// Line three not set as input: its edges must not start a burst.
		wr(8'h00, 32'h35);
		fire[1] <= 1'h1;
		@(posedge clk_i);
		fire[1] <= 1'h0;
		watch(10, s);
		chkb("start_trigger_o", 1'h0, s);
		$display("test lines done");
	endtask : t_lines
	task automatic final_report;
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0)
		begin
			$display("DONE - PASS");
		end
		else
		begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : final_report
	initial
	begin
		repeat (2) @(posedge clk_i);
		rst_i <= 1'h0;
		t_soft();
		t_lines();
		final_report();
	end
	// The run needs well under a thousand cycles.
	initial
	begin
		#100000;
		n_mismatch++;
		final_report();
	end
endmodule : tb
`default_nettype wire
